// ---- verilog/pwst_pkg.sv ----
// Shared constants, encodings and carrier types of the prescaler and wake standby timer.
`default_nettype none
package pwst_pkg;

   // Counter widths.
   localparam int unsigned SYS_W = 13;
   localparam int unsigned WATCH_W = 5;
   localparam int unsigned DIV4_W = 2;
   localparam int unsigned PRE_W = 7;
   localparam int unsigned STBY_W = 15;
   localparam int unsigned SETTLE_W = 10;

   // Reset values of the two prescalers, and the last count of the divide-by-4 stage.
   localparam logic [12:0] SYS_RESET = 13'h0000;
   localparam logic [4:0] WATCH_RESET = 5'h00;
   localparam logic [1:0] DIV4_RESET = 2'h0;
   localparam logic [1:0] DIV4_LAST = 2'h3;

   // Tap fabric: 13 system taps followed by 8 watch taps.
   localparam int unsigned N_SYS_TAPS = 13;
   localparam int unsigned N_WATCH_TAPS = 8;
   localparam int unsigned N_TAPS = 21;
   localparam int unsigned TAP_SEL_W = 5;
   localparam logic [4:0] TAP_SEL_LAST = 5'h14;
   localparam int unsigned N_PERIPH = 6;

   // Power mode codes presented by the power controller.
   localparam logic [2:0] MODE_ACT_HIGH = 3'h0;
   localparam logic [2:0] MODE_ACT_MED = 3'h1;
   localparam logic [2:0] MODE_SLP_HIGH = 3'h2;
   localparam logic [2:0] MODE_SLP_MED = 3'h3;
   localparam logic [2:0] MODE_SUBACT = 3'h4;
   localparam logic [2:0] MODE_SUBSLP = 3'h5;
   localparam logic [2:0] MODE_WATCH = 3'h6;
   localparam logic [2:0] MODE_STANDBY = 3'h7;

   // Medium-speed input divider: terminal counts for divide by 16, 32, 64 and 128.
   localparam logic [1:0] MED_SEL_16 = 2'h0;
   localparam logic [1:0] MED_SEL_32 = 2'h1;
   localparam logic [1:0] MED_SEL_64 = 2'h2;
   localparam logic [1:0] MED_SEL_128 = 2'h3;
   localparam logic [6:0] MED_TC_16 = 7'h0f;
   localparam logic [6:0] MED_TC_32 = 7'h1f;
   localparam logic [6:0] MED_TC_64 = 7'h3f;
   localparam logic [6:0] MED_TC_128 = 7'h7f;

   // Field positions in the first system control register and the timer A mode register.
   localparam int unsigned STS_MSB = 6;
   localparam int unsigned STS_LSB = 4;
   localparam int unsigned TMA_CLR_B3 = 3;
   localparam int unsigned TMA_CLR_B2 = 2;

   // Standby lengths in states, indexed by the 3-bit select code.
   localparam logic [14:0] STBY_MIN = 15'h0008;
   localparam logic [7:0][14:0] STBY_TABLE = {
      15'h0100, 15'h0008, 15'h0010, 15'h1000, 15'h0800, 15'h0400, 15'h4000, 15'h2000};

   // Oscillator settling time; a least time, so the cycle count rounds up.
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned OSC_SETTLE_NS = 10000;
   localparam logic [9:0] OSC_SETTLE_CYC = 10'((OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Wake sequencer states.
   typedef enum logic [3:0] {
      WK_RUN = 4'b0001,
      WK_HALT = 4'b0010,
      WK_SETTLE = 4'b0100,
      WK_STBY = 4'b1000
   } pwst_wake_t;

   // Clock taps handed to the peripherals.
   typedef struct packed {
      logic [7:0] watch;
      logic [12:0] sys;
   } pwst_taps_t;

   // Whole state of the main module.
   typedef struct packed {
      pwst_wake_t wake;
      logic [12:0] sys_cnt;
      logic [6:0] pre_cnt;
      logic [1:0] sub_sync;
      logic sub_prev;
      logic [1:0] div4;
      logic [4:0] watch_cnt;
      logic [14:0] wait_cnt;
      logic [9:0] settle_cnt;
      pwst_taps_t taps;
      logic osc_run;
      logic cpu_hold;
      logic wake_done;
   } pwst_state_t;

   // Whole state of one tap selector.
   typedef struct packed {
      logic prev;
      logic tick;
   } pwst_sel_state_t;

endpackage
`default_nettype wire

// ---- verilog/pwst_tap_select.sv ----
// One peripheral's private choice of prescaler tap, turned into a one-cycle tick.
`timescale 1ns/1ps
`default_nettype none
module pwst_tap_select (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire pwst_pkg::pwst_taps_t taps,
   input wire logic [4:0] sel,
   output logic tick
);

   pwst_pkg::pwst_sel_state_t state_reg;
   pwst_pkg::pwst_sel_state_t state_next;
   logic [20:0] tap_vec;
   logic level;

   assign tap_vec = {taps.watch, taps.sys};

   always_comb begin
      state_next = state_reg;
      if (sel <= pwst_pkg::TAP_SEL_LAST) begin
         level = tap_vec[sel];
      end else begin
         level = 1'b0;
      end
      // A rising edge of the chosen tap is one period of the divided clock.
      state_next.tick = level & ~state_reg.prev;
      state_next.prev = level;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= '0;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   assign tick = state_reg.tick;

endmodule // pwst_tap_select
`default_nettype wire

// ---- verilog/pwst_top.sv ----
// System and watch prescalers, peripheral tap selection and the wake-up standby timer.
`timescale 1ns/1ps
`default_nettype none
module pwst_top #(
   parameter logic [7:0][14:0] STBY_LEN = pwst_pkg::STBY_TABLE
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic [2:0] power_mode,
   input wire logic [1:0] med_div_sel,
   input wire logic wake_accept,
   input wire logic [7:0] system_control_one,
   input wire logic [7:0] timer_a_mode_reg,
   input wire logic timer_a_mode_wr,
   input wire logic subclock_in_pin,
   input wire logic [5:0][4:0] periph_tap_sel,
   output logic [5:0] periph_tick,
   output pwst_pkg::pwst_taps_t taps,
   output logic osc_enable,
   output logic cpu_hold,
   output logic wake_done
);

   pwst_pkg::pwst_state_t state_reg;
   pwst_pkg::pwst_state_t state_next;

   logic mode_stop;
   logic mode_med;
   logic sys_run;
   logic phi_on;
   logic [6:0] pre_tc;
   logic phi_tick;
   logic sub_rise;
   logic tma_clear;
   logic [2:0] stby_sel;
   logic [14:0] stby_len;

   // Modes in which the system oscillator is stopped, and the two medium-speed modes.
   always_comb begin
      mode_stop = (power_mode == pwst_pkg::MODE_STANDBY) ||
                  (power_mode == pwst_pkg::MODE_WATCH) ||
                  (power_mode == pwst_pkg::MODE_SUBACT) ||
                  (power_mode == pwst_pkg::MODE_SUBSLP);
      mode_med = (power_mode == pwst_pkg::MODE_ACT_MED) ||
                 (power_mode == pwst_pkg::MODE_SLP_MED);
   end

   always_comb begin
      if (med_div_sel == pwst_pkg::MED_SEL_16) begin
         pre_tc = pwst_pkg::MED_TC_16;
      end else if (med_div_sel == pwst_pkg::MED_SEL_32) begin
         pre_tc = pwst_pkg::MED_TC_32;
      end else if (med_div_sel == pwst_pkg::MED_SEL_64) begin
         pre_tc = pwst_pkg::MED_TC_64;
      end else begin
         pre_tc = pwst_pkg::MED_TC_128;
      end
   end

   assign stby_sel = system_control_one[pwst_pkg::STS_MSB:pwst_pkg::STS_LSB];

   always_comb begin
      stby_len = STBY_LEN[stby_sel];
      if (stby_len < pwst_pkg::STBY_MIN) begin
         stby_len = pwst_pkg::STBY_MIN;
      end
   end

   assign tma_clear = timer_a_mode_wr &&
                      timer_a_mode_reg[pwst_pkg::TMA_CLR_B3] &&
                      timer_a_mode_reg[pwst_pkg::TMA_CLR_B2];

   // The system clock runs in the run state outside the stop modes, and also
   // during the standby wait, where the recovered clock is already stable.
   assign sys_run = (state_reg.wake == pwst_pkg::WK_RUN) && !mode_stop;
   assign phi_on = sys_run || (state_reg.wake == pwst_pkg::WK_STBY);

   // One system clock period: every cycle at high speed, one in N at medium speed.
   assign phi_tick = phi_on && (!mode_med || (state_reg.pre_cnt == pre_tc));

   // Only the second synchroniser stage and its delayed copy are compared.
   assign sub_rise = state_reg.sub_sync[1] && !state_reg.sub_prev;

   always_comb begin
      state_next = state_reg;
      state_next.wake_done = 1'b0;

      // Subclock pin passes two flip-flops before use.
      state_next.sub_sync = {state_reg.sub_sync[0], subclock_in_pin};
      state_next.sub_prev = state_reg.sub_sync[1];

      // Medium-speed predivider; held at zero while the system clock is stopped.
      if (!phi_on || !mode_med || (state_reg.pre_cnt == pre_tc)) begin
         state_next.pre_cnt = 7'h00;
      end else begin
         state_next.pre_cnt = state_reg.pre_cnt + 7'h01;
      end

      if (!sys_run) begin
         state_next.sys_cnt = pwst_pkg::SYS_RESET;
      end else if (phi_tick) begin
         state_next.sys_cnt = state_reg.sys_cnt + 13'h0001;
      end

      if (sub_rise) begin
         state_next.div4 = state_reg.div4 + 2'h1;
      end
      if (tma_clear) begin
         state_next.watch_cnt = pwst_pkg::WATCH_RESET;
      end else if (sub_rise && (state_reg.div4 == pwst_pkg::DIV4_LAST)) begin
         state_next.watch_cnt = state_reg.watch_cnt + 5'h01;
      end

      state_next.taps.sys = state_next.sys_cnt;
      state_next.taps.watch = {state_next.watch_cnt, state_next.div4, state_reg.sub_sync[1]};

      // Wake sequencer.
      case (state_reg.wake)
         pwst_pkg::WK_RUN: begin
            state_next.cpu_hold = 1'b0;
            state_next.osc_run = 1'b1;
            if (mode_stop) begin
               state_next.wake = pwst_pkg::WK_HALT;
               state_next.osc_run = 1'b0;
               state_next.cpu_hold = 1'b1;
            end
         end
         pwst_pkg::WK_HALT: begin
            if (wake_accept) begin
               state_next.wake = pwst_pkg::WK_SETTLE;
               state_next.osc_run = 1'b1;
               state_next.settle_cnt = 10'h000;
            end
         end
         pwst_pkg::WK_SETTLE: begin
            if (state_reg.settle_cnt == (pwst_pkg::OSC_SETTLE_CYC - 10'h001)) begin
               state_next.wake = pwst_pkg::WK_STBY;
               state_next.wait_cnt = 15'h0000;
            end else begin
               state_next.settle_cnt = state_reg.settle_cnt + 10'h001;
            end
         end
         pwst_pkg::WK_STBY: begin
            if (phi_tick) begin
               if (state_reg.wait_cnt == (stby_len - 15'h0001)) begin
                  state_next.wake = pwst_pkg::WK_RUN;
                  state_next.cpu_hold = 1'b0;
                  state_next.wake_done = 1'b1;
               end else begin
                  state_next.wait_cnt = state_reg.wait_cnt + 15'h0001;
               end
            end
         end
         default: begin
            state_next.wake = pwst_pkg::WK_RUN;
            state_next.cpu_hold = 1'b0;
            state_next.osc_run = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg.wake <= pwst_pkg::WK_RUN;
         state_reg.sys_cnt <= pwst_pkg::SYS_RESET;
         state_reg.pre_cnt <= 7'h00;
         state_reg.sub_sync <= 2'h0;
         state_reg.sub_prev <= 1'b0;
         state_reg.div4 <= pwst_pkg::DIV4_RESET;
         state_reg.watch_cnt <= pwst_pkg::WATCH_RESET;
         state_reg.wait_cnt <= 15'h0000;
         state_reg.settle_cnt <= 10'h000;
         state_reg.taps <= '0;
         state_reg.osc_run <= 1'b1;
         state_reg.cpu_hold <= 1'b0;
         state_reg.wake_done <= 1'b0;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   assign taps = state_reg.taps;
   assign osc_enable = state_reg.osc_run;
   assign cpu_hold = state_reg.cpu_hold;
   assign wake_done = state_reg.wake_done;

   genvar gi;
   generate
      for (gi = 0; gi < pwst_pkg::N_PERIPH; gi = gi + 1) begin : g_periph
         pwst_tap_select u_sel (
            .clk_sys(clk_sys),
            .rst(rst),
            .ce(ce),
            .taps(state_reg.taps),
            .sel(periph_tap_sel[gi]),
            .tick(periph_tick[gi])
         );
      end
   endgenerate

endmodule // pwst_top
`default_nettype wire

// ---- verification/pwst_properties.sv ----
// Concurrent checks on the ports of the prescaler and wake standby timer.
`timescale 1ns/1ps
`default_nettype none
module pwst_checker #(
   parameter logic [7:0][14:0] STBY_LEN = pwst_pkg::STBY_TABLE
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic [2:0] power_mode,
   input wire logic wake_accept,
   input wire logic [7:0] system_control_one,
   input wire logic [7:0] timer_a_mode_reg,
   input wire logic timer_a_mode_wr,
   input wire logic [5:0][4:0] periph_tap_sel,
   input wire logic [5:0] periph_tick,
   input wire pwst_pkg::pwst_taps_t taps,
   input wire logic osc_enable,
   input wire logic cpu_hold,
   input wire logic wake_done
);
   logic [15:0] hold_cnt_reg;
   logic [14:0] len_w;
   logic tap0;
   function automatic logic sel_tap(pwst_pkg::pwst_taps_t t, logic [4:0] s);
      if (s < 5'h0d) begin
         return t.sys[s];
      end
      return (s <= pwst_pkg::TAP_SEL_LAST) ? t.watch[s - 5'h0d] : 1'b0;
   endfunction
   assign tap0 = sel_tap(taps, periph_tap_sel[0]);
   // Short codes are clamped, so the expected wait never drops below the floor.
   assign len_w = (STBY_LEN[system_control_one[6:4]] < 15'h0008) ? 15'h0008 : STBY_LEN[system_control_one[6:4]];
   always_ff @(posedge clk_sys) begin
      if (rst || !(cpu_hold && osc_enable)) begin
         hold_cnt_reg <= 16'h0000;
      end else if (ce) begin
         hold_cnt_reg <= hold_cnt_reg + 16'h0001;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_sys_step: assert property (power_mode inside {3'h0, 3'h2} && ce && !cpu_hold ##1 !cpu_hold
      |-> taps.sys == $past(taps.sys) + 13'h0001) else $error("system count step wrong");
   a_sys_halt: assert property (cpu_hold && $past(cpu_hold) |-> taps.sys == 13'h0000)
      else $error("system count not zero while halted");
   a_reset_clear: assert property (@(posedge clk_sys) disable iff (1'b0) rst
      |=> taps == '0 && !cpu_hold && osc_enable && !wake_done) else $error("reset values wrong");
   a_watch_clear: assert property (timer_a_mode_wr && timer_a_mode_reg[3] && timer_a_mode_reg[2] && ce
      |=> taps.watch[7:3] == 5'h00) else $error("watch count not cleared");
   a_watch_step: assert property ($changed(taps.watch[7:3]) && !$past(timer_a_mode_wr) && !$past(rst)
      |-> taps.watch[7:3] == $past(taps.watch[7:3]) + 5'h01 && taps.watch[2:1] == 2'h0)
      else $error("watch count step wrong");
   a_osc_stop: assert property ($rose(cpu_hold) |-> !osc_enable) else $error("oscillator left running");
   a_wake_start: assert property (cpu_hold && !osc_enable && wake_accept && ce |=> osc_enable)
      else $error("oscillator did not restart");
   a_osc_stays_off: assert property (!osc_enable && !wake_accept |=> !osc_enable)
      else $error("oscillator restarted without wake");
   a_hold_release: assert property ($fell(cpu_hold) && !$past(rst) |-> wake_done && osc_enable)
      else $error("hold released outside wake end");
   a_wake_exact: assert property (wake_done && power_mode inside {3'h0, 3'h2}
      |-> hold_cnt_reg == 16'(pwst_pkg::OSC_SETTLE_CYC) + 16'(len_w)) else $error("wake length wrong");
   a_tick_timer_a: assert property ($rose(tap0) |=> !ce || periph_tick[0])
      else $error("timer tick missing");
   a_tick_none: assert property (periph_tap_sel[5] > pwst_pkg::TAP_SEL_LAST |-> !periph_tick[5])
      else $error("tick on unused select");
   cover property (wake_done);
   cover property (cpu_hold && wake_accept);
   cover property (periph_tick[0]);
endmodule // pwst_checker
bind pwst_top pwst_checker #(.STBY_LEN(STBY_LEN)) u_chk (
   .clk_sys(clk_sys), .rst(rst), .ce(ce), .power_mode(power_mode), .wake_accept(wake_accept),
   .system_control_one(system_control_one), .timer_a_mode_reg(timer_a_mode_reg),
   .timer_a_mode_wr(timer_a_mode_wr), .periph_tap_sel(periph_tap_sel), .periph_tick(periph_tick),
   .taps(taps), .osc_enable(osc_enable), .cpu_hold(cpu_hold), .wake_done(wake_done)
);
`default_nettype wire

// ---- verification/pwst_periph_model.sv ----
// Far-side model: supplies the watch clock and counts each peripheral's ticks.
`timescale 1ns/1ps
`default_nettype none
module pwst_periph_model #(
   parameter int SUB_HALF_NS = 160
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [5:0] periph_tick,
   output logic subclock_in_pin,
   output logic [5:0][15:0] tick_cnt
);
   initial begin
      subclock_in_pin = 1'b0;
      #7;
      forever #(SUB_HALF_NS) subclock_in_pin = ~subclock_in_pin;
   end
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < 6; i++) begin
         if (rst) begin
            tick_cnt[i] <= 16'h0000;
         end else if (periph_tick[i]) begin
            tick_cnt[i] <= tick_cnt[i] + 16'h0001;
         end
      end
   end
endmodule // pwst_periph_model
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the prescaler and wake standby timer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [7:0][14:0] LEN = {15'h000f, 15'h000e, 15'h000d, 15'h000c, 15'h000b, 15'h000a, 15'h0009, 15'h0008};
   logic clk_sys, rst, ce, wake_accept, timer_a_mode_wr, osc_enable, cpu_hold, wake_done, subclock_in_pin;
   logic [2:0] power_mode;
   logic [1:0] med_div_sel;
   logic [7:0] system_control_one, timer_a_mode_reg;
   logic [5:0][4:0] periph_tap_sel;
   logic [5:0] periph_tick;
   logic [5:0][15:0] tick_cnt;
   pwst_pkg::pwst_taps_t taps;
   int errors, checks_done, n;
   logic [12:0] v;
   logic [4:0] w;
   pwst_top #(.STBY_LEN(LEN)) uut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .power_mode(power_mode),
      .med_div_sel(med_div_sel), .wake_accept(wake_accept), .system_control_one(system_control_one),
      .timer_a_mode_reg(timer_a_mode_reg), .timer_a_mode_wr(timer_a_mode_wr), .subclock_in_pin(subclock_in_pin),
      .periph_tap_sel(periph_tap_sel), .periph_tick(periph_tick), .taps(taps), .osc_enable(osc_enable),
      .cpu_hold(cpu_hold), .wake_done(wake_done));
   pwst_periph_model model (.clk_sys(clk_sys), .rst(rst), .periph_tick(periph_tick),
      .subclock_in_pin(subclock_in_pin), .tick_cnt(tick_cnt));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("Checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   // Counts edges up to the next change of the system count; bounded so a stall ends the run.
   task automatic wait_sys(output int cnt);
      logic [12:0] old;
      old = taps.sys;
      cnt = 0;
      while (taps.sys === old) begin
         cyc(1);
         cnt++;
         if (cnt > 300) begin
            errors++;
            print_verdict();
         end
      end
   endtask
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      power_mode = 3'h0;
      med_div_sel = 2'h0;
      wake_accept = 1'b0;
      system_control_one = 8'h00;
      timer_a_mode_reg = 8'h00;
      timer_a_mode_wr = 1'b0;
      periph_tap_sel = {5'h1f, 5'h03, 5'h0d, 5'h0c, 5'h00, 5'h14};
      cyc(3);
      chk(32'(taps), 32'h0);
      @(posedge clk_sys);
      rst <= 1'b0;
      cyc(20);
      chk(32'(taps.sys), 32'h14);
      v = taps.sys;
      cyc(8292);
      chk(32'(taps.sys), 32'(13'(v + 13'h0064)));
      @(posedge clk_sys);
      ce <= 1'b0;
      cyc(2);
      v = taps.sys;
      cyc(10);
      chk(32'(taps.sys), 32'(v));
      @(posedge clk_sys);
      ce <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_sys);
         power_mode <= k[0] ? 3'h3 : 3'h1;
         med_div_sel <= 2'(k);
         #1;
         wait_sys(n);
         wait_sys(n);
         chk(32'(n), 32'h10 << k);
      end
      @(posedge clk_sys);
      power_mode <= 3'h0;
      timer_a_mode_reg <= 8'h0c;
      timer_a_mode_wr <= 1'b1;
      @(posedge clk_sys);
      timer_a_mode_wr <= 1'b0;
      wake_accept <= 1'b1;
      #1;
      // Looked at right after the clearing edge, before the next subclock step can move it.
      chk(32'(taps.watch[7:3]), 32'h0);
      @(posedge clk_sys);
      wake_accept <= 1'b0;
      #1;
      chk({30'h0, osc_enable, cpu_hold}, 32'h2);
      for (int c = 0; c < 8; c++) begin
         @(posedge clk_sys);
         system_control_one <= {1'b0, 3'(c), 4'h0};
         power_mode <= 3'h4 + 3'(c % 4);
         cyc(3);
         chk({29'h0, osc_enable, cpu_hold, |taps.sys}, 32'h2);
         w = taps.watch[7:3];
         cyc(200);
         chk(32'(taps.watch[7:3] !== w), 32'h1);
         @(posedge clk_sys);
         power_mode <= c[0] ? 3'h2 : 3'h0;
         wake_accept <= 1'b1;
         @(posedge clk_sys);
         wake_accept <= 1'b0;
         n = 1;
         #1;
         while (wake_done !== 1'b1 && n < 20000) begin
            cyc(1);
            n++;
         end
         // The count starts at one on the accepting edge, so one less is the edges until release.
         chk(32'(n - 1), 32'(pwst_pkg::OSC_SETTLE_CYC) + 32'(LEN[c]));
         if (n >= 20000) begin
            print_verdict();
         end
         chk(32'(cpu_hold), 32'h0);
      end
      chk(32'(tick_cnt[5]), 32'h0);
      chk(32'(tick_cnt[1] > tick_cnt[2]), 32'h1);
      chk(32'(tick_cnt[0] != 16'h0000), 32'h1);
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
